// ---- dams_pkg.sv ----
package dams_pkg;

   localparam int          ADDR_W          = 10;

   // register index; byte address is four times the index
   localparam logic [7:0]  IDX_STATUS      = 8'hd0;
   localparam logic [7:0]  IDX_MODE        = 8'hd1;
   localparam logic [7:0]  IDX_PCTL        = 8'hd2;
   localparam logic [7:0]  IDX_ACTL        = 8'hd3;
   localparam logic [7:0]  IDX_DECIM       = 8'hd4;
   localparam logic [7:0]  IDX_PRES        = 8'hd5;
   localparam logic [7:0]  IDX_ARES        = 8'hd6;
   localparam logic [7:0]  IDX_POFS        = 8'hd7;
   localparam logic [7:0]  IDX_PGAIN       = 8'hd8;
   localparam logic [7:0]  IDX_AOFS        = 8'hd9;
   localparam logic [7:0]  IDX_AGAIN       = 8'hda;

   localparam logic [7:0]  MODE_RST        = 8'h00;
   localparam logic [6:0]  PCTL_RST        = 7'h07;
   localparam logic [6:0]  ACTL_RST        = 7'h00;
   localparam logic [7:0]  DECIM_RST       = 8'h45;
   localparam logic [7:0]  DECIM_MAX       = 8'hff;
   localparam logic [15:0] CAL_RST         = 16'h0000;

   localparam int          MODE_EN0_BIT    = 5;
   localparam int          MODE_EN1_BIT    = 4;
   localparam int          CTL_XREF_BIT    = 6;
   localparam int          CTL_UNI_BIT     = 3;

   localparam logic [1:0]  AUX_TEMP_SEL    = 2'h2;
   localparam logic [2:0]  AUX_FIXED_RANGE = 3'h7;
   localparam logic [1:0]  ALIGN_OUTPUTS   = 2'h3;
   localparam logic [7:0]  MOD_DIV_CYC     = 8'h04;

   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [2:0] {
      MD_PDOWN  = 3'h0,
      MD_IDLE   = 3'h1,
      MD_SINGLE = 3'h2,
      MD_CONT   = 3'h3,
      MD_ZS_INT = 3'h4,
      MD_FS_INT = 3'h5,
      MD_ZS_SYS = 3'h6,
      MD_FS_SYS = 3'h7
   } dams_mode_e;

   typedef enum logic [3:0] {
      SQ_OFF  = 4'h1,
      SQ_IDLE = 4'h2,
      SQ_CONV = 4'h4,
      SQ_CAL  = 4'h8
   } dams_seq_e;

   typedef struct packed {
      logic       mod_clk_en;
      logic       filt_rst;
      logic       short_in;
      logic       ref_in;
      logic       ext_ref;
      logic [1:0] chan;
      logic       unipolar;
      logic [2:0] range;
   } dams_afe_s;

   localparam dams_afe_s AFE_RST = 11'h200;

endpackage : dams_pkg

// ---- dams_rate_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module dams_rate_timer (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       clk_on_i,
   input  wire logic       run_i,
   input  wire logic       restart_i,
   input  wire logic [7:0] decim_i,
   output logic            tick_o,
   output logic            done_o
);
   import dams_pkg::*;

   logic [7:0]  pre;
   logic [10:0] cnt;
   logic        tick_en;

   assign tick_en = clk_on_i && (pre == MOD_DIV_CYC - 8'h01);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre <= 8'h00;
      end else if (!clk_on_i || tick_en) begin
         pre <= 8'h00;
      end else begin
         pre <= pre + 8'h01;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= tick_en;
      end
   end

   // filter held in reset: count restarts so the first output is a full period away
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt    <= 11'h000;
         done_o <= 1'b0;
      end else if (restart_i || !run_i) begin
         cnt    <= 11'h000;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (tick_en) begin
            if (cnt == {decim_i, 3'h7}) begin
               cnt    <= 11'h000;
               done_o <= 1'b1;
            end else begin
               cnt <= cnt + 11'h001;
            end
         end
      end
   end

endmodule : dams_rate_timer
`default_nettype wire

// ---- dams_aux_align.sv ----
`timescale 1ns/1ps
`default_nettype none
module dams_aux_align (
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   input  wire logic restart_i,
   input  wire logic aux_only_i,
   input  wire logic prim_run_i,
   input  wire logic prim_done_i,
   input  wire logic own_done_i,
   output logic      done_o
);
   import dams_pkg::*;

   logic [1:0] seen;
   logic       locked;

   assign locked = (seen == ALIGN_OUTPUTS - 2'h1);

   // an aux-only restart waits for primary outputs so both stay in phase
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seen <= ALIGN_OUTPUTS - 2'h1;
      end else if (restart_i) begin
         seen <= aux_only_i ? 2'h0 : ALIGN_OUTPUTS - 2'h1;
      end else if (prim_run_i && prim_done_i && !locked) begin
         seen <= seen + 2'h1;
      end
   end

   // primary idle: aux runs on its own timer
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_o <= 1'b0;
      end else if (restart_i) begin
         done_o <= 1'b0;
      end else if (prim_run_i) begin
         done_o <= prim_done_i && locked;
      end else begin
         done_o <= own_done_i;
      end
   end

endmodule : dams_aux_align
`default_nettype wire

// ---- dams_sequencer.sv ----
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - mode field zero means power-down, and it resets to zero.
// - idle holds filter and modulator in reset, modulator clocks keep running.
// - single mode converts once per enabled converter, updates, then mode returns 000.
// - continuous mode keeps updating results at the decimation rate.
// - internal zero-scale calibration shorts the enabled converter inputs.
// - internal full-scale calibration applies reference chosen by each external-ref bit.
// - any mode write except a lone aux enable rise resets both converters, even with unchanged value.
// - primary control write while enabled, or primary enable rising, resets both.
// - aux control write, or aux enable rising with nothing else changed, resets aux only.
// - after aux-only reset aux output aligns to primary, up to three outputs.
// - writing a calibration mode clears both ready flags immediately.
// - calibration end writes cal registers and flags, then mode returns 000.
// - aux calibration on temperature input sets ready and error, keeps cal registers.
// - calibrations always use the maximum decimation factor.
// - aux range is fixed; only primary range is selectable.
// - enable bit activates a converter; cleared enable powers it down.
// - calibration-done flag set at calibration end, cleared by starting mode write.
// - error flags cleared by a mode write that starts conversion or calibration.
module dams_sequencer (
   input  wire logic                     ref_clk_i,
   input  wire logic                     rst_n_i,
   input  wire logic                     awvalid_i,
   output logic                          awready_o,
   input  wire logic [dams_pkg::ADDR_W-1:0] awaddr_i,
   input  wire logic                     wvalid_i,
   output logic                          wready_o,
   input  wire logic [31:0]              wdata_i,
   input  wire logic [3:0]               wstrb_i,
   output logic                          bvalid_o,
   input  wire logic                     bready_i,
   output logic [1:0]                    bresp_o,
   input  wire logic                     arvalid_i,
   output logic                          arready_o,
   input  wire logic [dams_pkg::ADDR_W-1:0] araddr_i,
   output logic                          rvalid_o,
   input  wire logic                     rready_i,
   output logic [31:0]                   rdata_o,
   output logic [1:0]                    rresp_o,
   input  wire logic [15:0]              prim_sample_i,
   input  wire logic [15:0]              aux_sample_i,
   output dams_pkg::dams_afe_s           prim_afe_o,
   output dams_pkg::dams_afe_s           aux_afe_o
);
   import dams_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      return a == {idx, 2'h0};
   endfunction : hit

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:2] >= IDX_STATUS && a[ADDR_W-1:2] <= IDX_AGAIN && a[1:0] == 2'h0;
   endfunction : mapped

   function automatic logic clamped(input logic [15:0] s);
      return s == 16'h0000 || s == 16'hffff;
   endfunction : clamped

   logic                    aw_hold, w_hold, wr_fire, wr_lane, ar_fire;
   logic [ADDR_W-1:0]       aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    wr_mode, wr_pctl, wr_actl, wr_decim;
   logic [7:0]              wd;
   dams_mode_e              md, new_md;
   logic                    en0, en1, new_en0, new_en1;
   logic [6:0]              pctl, actl;
   logic [7:0]              decim, cur_decim;
   logic [15:0]             pres, ares, pofs, pgain, aofs, again;
   logic                    primary_ready_flag, aux_ready_flag, cal_done, primary_error_flag, aux_error_flag, pend0, pend1;
   dams_seq_e               state, next_state;
   logic                    aux_only_wr, full_rst, aux_rst, start, start_cal;
   logic                    run_state, cal_mode, busy, clk_on, prim_run, aux_run;
   logic                    prim_tick, prim_done, aux_tick, aux_own_done, aux_al_done;
   logic                    p_done, a_done, p_take, a_take, fin, aux_temp;
   logic                    rd_pres, rd_ares;
   logic [31:0]             rd_mux;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   // write address and data are taken independently and joined here
   assign awready_o = !aw_hold;
   assign wready_o  = !w_hold;
   assign arready_o = !rvalid_o;
   assign wr_fire   = aw_hold && w_hold && !bvalid_o;
   assign ar_fire   = arvalid_i && arready_o;
   assign wr_lane   = wr_fire && w_strb[0];
   assign wd        = w_data[7:0];
   assign wr_mode   = wr_lane && hit(aw_addr, IDX_MODE);
   assign wr_pctl   = wr_lane && hit(aw_addr, IDX_PCTL);
   assign wr_actl   = wr_lane && hit(aw_addr, IDX_ACTL);
   assign wr_decim  = wr_lane && hit(aw_addr, IDX_DECIM);
   assign new_md    = dams_mode_e'(wd[2:0]);
   assign new_en0   = wd[MODE_EN0_BIT];
   assign new_en1   = wd[MODE_EN1_BIT];

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_hold <= 1'b0;
         aw_addr <= '0;
      end else if (awvalid_i && awready_o) begin
         aw_hold <= 1'b1;
         aw_addr <= awaddr_i;
      end else if (wr_fire) begin
         aw_hold <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         w_hold <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (wvalid_i && wready_o) begin
         w_hold <= 1'b1;
         w_data <= wdata_i;
         w_strb <= wstrb_i;
      end else if (wr_fire) begin
         w_hold <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bvalid_o <= 1'b0;
         bresp_o  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_o <= 1'b1;
         bresp_o  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_i) begin
         bvalid_o <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (araddr_i[ADDR_W-1:2])
         IDX_STATUS: rd_mux[7:0] = {primary_ready_flag, aux_ready_flag, cal_done, 1'b0, primary_error_flag, aux_error_flag, 2'h0};
         IDX_MODE:   rd_mux[7:0] = {2'h0, en0, en1, 1'b0, md};
         IDX_PCTL:   rd_mux[6:0] = pctl;
         IDX_ACTL:   rd_mux[6:0] = actl;
         IDX_DECIM:  rd_mux[7:0] = decim;
         IDX_PRES:   rd_mux[15:0] = pres;
         IDX_ARES:   rd_mux[15:0] = ares;
         IDX_POFS:   rd_mux[15:0] = pofs;
         IDX_PGAIN:  rd_mux[15:0] = pgain;
         IDX_AOFS:   rd_mux[15:0] = aofs;
         IDX_AGAIN:  rd_mux[15:0] = again;
         default:    rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rvalid_o <= 1'b0;
         rdata_o  <= 32'h0000_0000;
         rresp_o  <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_o <= 1'b1;
         rdata_o  <= mapped(araddr_i) ? rd_mux : 32'h0000_0000;
         rresp_o  <= mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready_i) begin
         rvalid_o <= 1'b0;
      end
   end

   // reading a result acknowledges its ready flag
   assign rd_pres = ar_fire && hit(araddr_i, IDX_PRES);
   assign rd_ares = ar_fire && hit(araddr_i, IDX_ARES);

   // aux enable rising with nothing else changed must not disturb the primary
   assign aux_only_wr = wr_mode && new_md == md && new_en0 == en0 && !en1 && new_en1;
   assign full_rst    = (wr_mode && !aux_only_wr) || (wr_pctl && en0);
   assign aux_rst     = full_rst || wr_actl || aux_only_wr;
   assign start       = wr_mode && !aux_only_wr && new_md >= MD_SINGLE
                        && (new_en0 || new_en1);
   assign start_cal   = start && new_md[2];

   always_comb begin
      case (1'b1)
         (!en0 && !en1) || md == MD_PDOWN: next_state = SQ_OFF;
         md == MD_IDLE:                    next_state = SQ_IDLE;
         md[2]:                            next_state = SQ_CAL;
         default:                          next_state = SQ_CONV;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= SQ_OFF;
      end else begin
         state <= next_state;
      end
   end

   assign run_state = state == SQ_CONV || state == SQ_CAL;
   assign cal_mode  = state == SQ_CAL;
   assign busy      = (state == SQ_CONV && md == MD_CONT) || pend0 || pend1;
   assign clk_on    = state != SQ_OFF;
   assign prim_run  = run_state && en0 && busy;
   assign aux_run   = run_state && en1 && busy;
   assign cur_decim = cal_mode ? DECIM_MAX : decim;
   assign aux_temp  = actl[5:4] == AUX_TEMP_SEL;

   dams_rate_timer u_prim_timer (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .clk_on_i  (clk_on && en0),
      .run_i     (prim_run),
      .restart_i (full_rst),
      .decim_i   (cur_decim),
      .tick_o    (prim_tick),
      .done_o    (prim_done)
   );

   dams_rate_timer u_aux_timer (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .clk_on_i  (clk_on && en1),
      .run_i     (aux_run && !prim_run),
      .restart_i (aux_rst),
      .decim_i   (cur_decim),
      .tick_o    (aux_tick),
      .done_o    (aux_own_done)
   );

   dams_aux_align u_align (
      .ref_clk_i   (ref_clk_i),
      .rst_n_i     (rst_n_i),
      .restart_i   (aux_rst),
      .aux_only_i  (!full_rst),
      .prim_run_i  (prim_run),
      .prim_done_i (p_done),
      .own_done_i  (aux_own_done),
      .done_o      (aux_al_done)
   );

   assign p_done = prim_done && prim_run;
   assign a_done = aux_al_done && aux_run;
   assign p_take = p_done && (pend0 || md == MD_CONT) && !wr_mode;
   assign a_take = a_done && (pend1 || md == MD_CONT) && !wr_mode;
   assign fin    = (pend0 || pend1) && !wr_mode
                   && !(pend0 && en0 && !p_take) && !(pend1 && en1 && !a_take);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {en0, en1} <= MODE_RST[5:4];
         md         <= dams_mode_e'(MODE_RST[2:0]);
      end else if (wr_mode) begin
         en0 <= new_en0;
         en1 <= new_en1;
         md  <= new_md;
      end else if (fin) begin
         md <= MD_PDOWN;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pctl  <= PCTL_RST;
         actl  <= ACTL_RST;
         decim <= DECIM_RST;
      end else begin
         if (wr_pctl) pctl <= wd[6:0];
         if (wr_actl) actl <= wd[6:0];
         if (wr_decim) decim <= wd;
      end
   end

   // one pending conversion per enabled converter in single and calibration modes
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend0 <= 1'b0;
         pend1 <= 1'b0;
      end else if (wr_mode && !aux_only_wr) begin
         pend0 <= (new_md == MD_SINGLE || new_md[2]) && new_en0;
         pend1 <= (new_md == MD_SINGLE || new_md[2]) && new_en1;
      end else begin
         pend0 <= pend0 && en0 && !p_take;
         pend1 <= pend1 && (en1 || aux_only_wr) && !a_take;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pres  <= 16'h0000;
         pofs  <= CAL_RST;
         pgain <= CAL_RST;
      end else if (p_take) begin
         if (!cal_mode) pres <= prim_sample_i;
         else if (!md[0]) pofs <= prim_sample_i;
         else pgain <= prim_sample_i;
      end
   end

   // temperature input cannot be calibrated: coefficients stay as they were
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ares  <= 16'h0000;
         aofs  <= CAL_RST;
         again <= CAL_RST;
      end else if (a_take) begin
         if (!cal_mode) ares <= aux_sample_i;
         else if (aux_temp) ares <= ares;
         else if (!md[0]) aofs <= aux_sample_i;
         else again <= aux_sample_i;
      end
   end

   // hardware set wins over every clear in the same cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         primary_ready_flag     <= 1'b0;
         aux_ready_flag     <= 1'b0;
         primary_error_flag     <= 1'b0;
         aux_error_flag     <= 1'b0;
         cal_done <= 1'b0;
      end else begin
         if (p_take) primary_ready_flag <= 1'b1;
         else if (start_cal || rd_pres) primary_ready_flag <= 1'b0;
         if (a_take) aux_ready_flag <= 1'b1;
         else if (start_cal || rd_ares) aux_ready_flag <= 1'b0;
         if (p_take && !cal_mode && clamped(prim_sample_i)) primary_error_flag <= 1'b1;
         else if (start) primary_error_flag <= 1'b0;
         if (a_take && (cal_mode ? aux_temp : clamped(aux_sample_i))) aux_error_flag <= 1'b1;
         else if (start) aux_error_flag <= 1'b0;
         if (fin && cal_mode) cal_done <= 1'b1;
         else if (start) cal_done <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prim_afe_o <= AFE_RST;
         aux_afe_o  <= AFE_RST;
      end else begin
         prim_afe_o.mod_clk_en <= prim_tick;
         prim_afe_o.filt_rst   <= full_rst || !prim_run;
         prim_afe_o.short_in   <= prim_run && md == MD_ZS_INT;
         prim_afe_o.ref_in     <= prim_run && md == MD_FS_INT;
         prim_afe_o.ext_ref    <= pctl[CTL_XREF_BIT];
         prim_afe_o.chan       <= pctl[5:4];
         prim_afe_o.unipolar   <= pctl[CTL_UNI_BIT];
         prim_afe_o.range      <= pctl[2:0];
         aux_afe_o.mod_clk_en  <= aux_tick;
         aux_afe_o.filt_rst    <= aux_rst || !aux_run;
         aux_afe_o.short_in    <= aux_run && md == MD_ZS_INT;
         aux_afe_o.ref_in      <= aux_run && md == MD_FS_INT;
         aux_afe_o.ext_ref     <= actl[CTL_XREF_BIT];
         aux_afe_o.chan        <= actl[5:4];
         aux_afe_o.unipolar    <= actl[CTL_UNI_BIT];
         aux_afe_o.range       <= AUX_FIXED_RANGE;
      end
   end

   sequence s_idle_run;
      (state == SQ_IDLE && en0 && !wr_mode)[*8];
   endsequence

   chk_mode_back_off: assert property (
      fin |=> md == MD_PDOWN && !pend0 && !pend1)
      else $error("mode field not cleared after completion");

   chk_cal_ready_clear: assert property (
      start_cal && !p_take && !a_take |=> !primary_ready_flag && !aux_ready_flag)
      else $error("ready flags survived calibration start");

   chk_both_reset: assert property (
      full_rst |=> prim_afe_o.filt_rst && aux_afe_o.filt_rst)
      else $error("mode or primary control write did not reset both");

   chk_aux_only_reset: assert property (
      aux_rst && !full_rst && prim_run |=> !prim_afe_o.filt_rst && aux_afe_o.filt_rst)
      else $error("aux-only reset disturbed primary");

   chk_idle_clocks: assert property (
      s_idle_run |-> prim_afe_o.filt_rst ##0 $past(prim_tick, 1) || $past(prim_tick, 2)
      || $past(prim_tick, 3) || $past(prim_tick, 4) || $past(prim_tick, 5))
      else $error("idle mode lost modulator clocks or released filter");

   chk_cal_decim: assert property (
      state == SQ_CAL |-> cur_decim == DECIM_MAX)
      else $error("calibration not at maximum decimation");

   chk_temp_cal_err: assert property (
      a_take && cal_mode && aux_temp |=> aux_error_flag && aux_ready_flag && $stable(aofs) && $stable(again))
      else $error("temperature calibration not flagged");

   chk_no_enable_quiet: assert property (
      !en0 && !en1 && !wr_mode && !rd_pres && !rd_ares
      |=> $stable({primary_ready_flag, aux_ready_flag, primary_error_flag, aux_error_flag, cal_done}))
      else $error("status moved with no converter enabled");

   chk_start_clears: assert property (
      start && !p_take && !a_take |=> !primary_error_flag && !aux_error_flag && !cal_done)
      else $error("start did not clear error or calibration flags");

   chk_disable_down: assert property (
      !en0 |=> ##1 prim_afe_o.filt_rst && !prim_afe_o.mod_clk_en)
      else $error("disabled primary not powered down");

endmodule : dams_sequencer
`default_nettype wire

// ---- test_dual_adc_mode_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_dual_adc_mode_sequencer;
   import dams_pkg::*;
   logic        ref_clk_i = 0;
   logic        rst_n_i = 0;
   logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic        awr, wr_r, bv, arr, rv;
   logic [9:0]  awa = 0, ara = 0;
   logic [31:0] wd = 0, rd_d;
   logic [1:0]  brsp, rrsp;
   logic [15:0] ps = 16'h1234, as = 16'h4321;
   logic        sys_on = 0;
   logic [15:0] sys_v = 16'h0000;
   dams_afe_s   pafe, aafe;
   logic [31:0] d;
   logic [1:0]  r;
   int          fails = 0, checks = 0, seed = 25676;
   always #50 ref_clk_i = ~ref_clk_i;
   // samples kept off 0000/ffff so no clamp error is raised
   always @(posedge ref_clk_i) begin
      // system calibration needs a steady input, so the random draw is overridden
      ps <= sys_on ? sys_v : ((16'($random(seed)) & 16'h7ffe) | 16'h0001);
      as <= (16'($random(seed)) & 16'h7ffe) | 16'h0001;
   end
   dams_sequencer i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .awvalid_i(awv),
      .awready_o(awr), .awaddr_i(awa), .wvalid_i(wv), .wready_o(wr_r), .wdata_i(wd),
      .wstrb_i(4'h1), .bvalid_o(bv), .bready_i(br), .bresp_o(brsp), .arvalid_i(arv),
      .arready_o(arr), .araddr_i(ara), .rvalid_o(rv), .rready_i(rr), .rdata_o(rd_d),
      .rresp_o(rrsp), .prim_sample_i(ps), .aux_sample_i(as), .prim_afe_o(pafe),
      .aux_afe_o(aafe));
   function automatic logic [31:0] st(logic r0, r1, cd, e0, e1);
      return {24'h0, r0, r1, cd, 1'b0, e0, e1, 2'b00};
   endfunction : st
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] i, input logic [7:0] v);
      awv <= 1; wv <= 1; br <= 1; awa <= {i, 2'b00}; wd <= {24'h0, v};
      do begin
         @(posedge ref_clk_i);
         if (awr) awv <= 0;
         if (wr_r) wv <= 0;
      end while (!bv);
      br <= 0;
      // one idle edge so a following call never re-raises bready in this time step
      @(posedge ref_clk_i);
   endtask : wr
   task automatic rd(input logic [9:0] a);
      arv <= 1; rr <= 1; ara <= a;
      do begin
         @(posedge ref_clk_i);
         if (arr) arv <= 0;
      end while (!rv);
      d = rd_d;
      r = rrsp;
      rr <= 0;
      @(posedge ref_clk_i);
   endtask : rd
   // a completed single conversion or calibration returns the mode to 000
   task automatic wait_pd;
      for (int i = 0; i < 500; i++) begin
         repeat (40) @(posedge ref_clk_i);
         rd({IDX_MODE, 2'b00});
         if (d[2:0] == 3'h0) break;
      end
   endtask : wait_pd
   task automatic finish_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      fails++;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1;
      @(posedge ref_clk_i);
      rd({IDX_MODE, 2'b00}); chk(d, 32'h0);
      rd({IDX_PCTL, 2'b00}); chk(d, 32'h07);
      rd({IDX_ACTL, 2'b00}); chk(d, 32'h00);
      rd(10'h3fc); chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(IDX_MODE, 8'h21); repeat (3) @(posedge ref_clk_i);
      chk(pafe.filt_rst, 1'b1);
      wr(IDX_MODE, 8'h22); wait_pd; chk(d[2:0], 3'h0);
      rd({IDX_STATUS, 2'b00}); chk(d, st(1, 0, 0, 0, 0));
      wr(IDX_MODE, 8'h24); repeat (3) @(posedge ref_clk_i);
      chk(pafe.short_in, 1'b1);
      wait_pd; rd({IDX_STATUS, 2'b00}); chk(d, st(1, 0, 1, 0, 0));
      wr(IDX_ACTL, 8'h20); wr(IDX_MODE, 8'h14); repeat (3) @(posedge ref_clk_i);
      chk(aafe.range, AUX_FIXED_RANGE);
      wait_pd; rd({IDX_STATUS, 2'b00}); chk(d, st(0, 1, 1, 0, 1));
      wr(IDX_MODE, 8'h02); repeat (3000) @(posedge ref_clk_i);
      rd({IDX_MODE, 2'b00}); chk(d, 32'h02);
      rd({IDX_STATUS, 2'b00}); chk(d, st(0, 1, 1, 0, 1));
      sys_on <= 1;
      sys_v <= 16'h0123;
      wr(IDX_DECIM, 8'h01);
      wr(IDX_MODE, 8'h26);
      repeat (1000) @(posedge ref_clk_i);
      rd({IDX_MODE, 2'b00});
      chk(d, 32'h26);
      wait_pd;
      rd({IDX_POFS, 2'b00});
      chk(d, 32'h0123);
      sys_v <= 16'hfedc;
      wr(IDX_MODE, 8'h27);
      wait_pd;
      rd({IDX_PGAIN, 2'b00});
      chk(d, 32'hfedc);
      rd({IDX_STATUS, 2'b00});
      chk(d, st(1, 0, 1, 0, 0));
      sys_on <= 0;
      wr(IDX_MODE, 8'h23);
      repeat (100) @(posedge ref_clk_i);
      rd({IDX_PRES, 2'b00});
      repeat (100) @(posedge ref_clk_i);
      rd({IDX_STATUS, 2'b00});
      chk(d, st(1, 0, 0, 0, 0));
      // aux joins a running primary: its first result waits for the third primary output
      wr(IDX_MODE, 8'h33);
      repeat (100) @(posedge ref_clk_i);
      rd({IDX_STATUS, 2'b00});
      chk(d, st(1, 0, 0, 0, 0));
      repeat (120) @(posedge ref_clk_i);
      rd({IDX_STATUS, 2'b00});
      chk(d, st(1, 1, 0, 0, 0));
      finish_test;
   end
endmodule : test_dual_adc_mode_sequencer
`default_nettype wire
